//--- hw/fsp_regs.vh
// Constants for the flash protection and identification host controller
// How it works
// [RULE_01] Device floats data bus while output gate is high; host reads with gate low. The model drives the inverted byte there instead.
// [RULE_02] Top five address bits select one of 32 sectors of 64 KB each.
// [RULE_03] High-voltage identify: id line elevated, select and gate low, strobe high.
// [RULE_04] Address bits six, one, zero low give maker code; zero high gives device code.
// [RULE_05] Bit one high returns one for a protected sector, zero otherwise.
// [RULE_06] Identification is also readable after the autoselect command, without high voltage.
// [RULE_07] Protected sectors refuse program and erase.
// [RULE_08] Unprotect re-enables program and erase on previously protected sectors.
// [RULE_09] Primary protect/unprotect needs hard clear elevated; other cycles use normal timing.
// [RULE_10] Host protects every unprotected sector before the first unprotect write.
// [RULE_11] Alternate programmer method elevates both id line and output gate.
// [RULE_12] All 32 protection flags start cleared.
// [RULE_13] Hard clear elevated makes protected sectors temporarily writable.
// [RULE_14] Removing elevation restores protection; stored flags unchanged.
// [RULE_15] Below lockout the device ignores writes and holds itself in reset.
// [RULE_16] Pulses under about 5 ns on control pins never start a write.
// [RULE_17] Write only with select and strobe low and gate high.
// [RULE_18] No command is taken on strobe rise if write was asserted at power-up.
// [RULE_19] Device powers up in read-array state without a command.
// [RULE_20] Elevated levels and lockout are separate synchronous indicator signals.
`ifndef FSP_REGS_VH
`define FSP_REGS_VH
`define FSP_CLK_MHZ      10
`define FSP_STEP_NS      100
`define FSP_STEP_CYC     ((`FSP_STEP_NS * `FSP_CLK_MHZ + 999) / 1000)
`define FSP_OP_READ      3'h0
`define FSP_OP_WRITE     3'h1
`define FSP_OP_ID_HV     3'h2
`define FSP_OP_TEMP_ON   3'h3
`define FSP_OP_TEMP_OFF  3'h4
`define FSP_OP_ALT_HV    3'h5
`define FSP_ID_MAKER     2'h0
`define FSP_ID_DEVICE    2'h1
`define FSP_ID_PROT      2'h2
`define FSP_SECT_LSB     16
`define FSP_PROT_BIT     0
`define FSP_UNPROT_BIT   6
`define FSP_SYNC_CYC     8'h02
`define FSP_ALL_PROT     32'hffffffff
`endif

//--- hw/fsp_host.v
// Host controller driving the flash control pins for reads, writes and protection
`timescale 1ns/100ps
`include "fsp_regs.vh"
module fsp_host (
	input  wire        i_clk,          // 10 MHz clock
	input  wire        i_reset,        // Sync reset, active high
	input  wire        i_req,          // Start request pulse
	input  wire [2:0]  i_op,           // Operation code
	input  wire [20:0] i_addr,         // Byte address
	input  wire [7:0]  i_wdata,        // Write data
	input  wire        i_lockout,      // Device supply below lockout
	input  wire [7:0]  i_data_in,      // Data bus from device
	output reg         o_busy,         // Operation in progress
	output reg         o_done,         // Operation finished pulse
	output reg  [7:0]  o_rdata,        // Captured read data
	output reg         o_refused,      // Write refused by lockout or by unprotect before all sectors protected
	output reg  [20:0] o_addr,         // Address pins
	output reg  [7:0]  o_data_out,     // Data bus drive value
	output reg         o_data_oe,      // Data bus drive enable
	output reg         o_chip_select_n,  // Chip select
	output reg         o_write_strobe_n, // Write strobe
	output reg         o_output_gate_n,  // Output gate
	output reg         o_id_hv,        // Elevate id line
	output reg         o_gate_hv,      // Elevate output gate
	output reg         o_clear_hv      // Elevate hard clear
);
	localparam [2:0]   ST_IDLE   = 3'h0;
	localparam [2:0]   ST_SETUP  = 3'h1;
	localparam [2:0]   ST_PULSE  = 3'h2;
	localparam [2:0]   ST_SAMPLE = 3'h3;
	localparam [2:0]   ST_HOLD   = 3'h4;
	localparam integer STEP_I    = `FSP_STEP_CYC;
	localparam [7:0]   STEP      = STEP_I[7:0];
	localparam [7:0]   SYNC_WAIT = `FSP_SYNC_CYC;

	reg  [2:0]  state;
	reg  [2:0]  op;
	reg  [7:0]  cnt;
	reg         lock_s0;
	reg         lock_s1;
	reg  [7:0]  data_s0;
	reg  [7:0]  data_s1;
	reg  [31:0] prot_map;
	wire        is_wr;
	wire        req_wr;
	wire        req_prot;
	wire        req_unprot;
	wire        map_full;
	wire [4:0]  req_sect;
	wire [4:0]  cur_sect;
	wire        id_prot_rd;

	assign is_wr      = (op == `FSP_OP_WRITE) || (op == `FSP_OP_ALT_HV);
	assign req_wr     = (i_op == `FSP_OP_WRITE) || (i_op == `FSP_OP_ALT_HV);
	// [RULE_09] protect cycles ride on hard clear
	assign req_prot   = req_wr && (o_clear_hv || (i_op == `FSP_OP_ALT_HV)) &&
	                    (i_addr[1:0] == `FSP_ID_PROT);
	assign req_unprot = req_prot && i_addr[`FSP_UNPROT_BIT];
	assign map_full   = (prot_map == `FSP_ALL_PROT);
	assign req_sect   = i_addr[20:`FSP_SECT_LSB];
	assign cur_sect   = o_addr[20:`FSP_SECT_LSB];
	assign id_prot_rd = (op == `FSP_OP_ID_HV) && (o_addr[1:0] == `FSP_ID_PROT) &&
	                    !o_addr[`FSP_UNPROT_BIT];

	always @(posedge i_clk) begin
		if (i_reset) begin
			lock_s0 <= 1'b0;
			lock_s1 <= 1'b0;
		end else begin
			lock_s0 <= i_lockout;
			lock_s1 <= lock_s0;
		end
	end

	// Data pins follow the device's own timing, not this clock
	always @(posedge i_clk) begin
		if (i_reset) begin
			data_s0 <= 8'h00;
			data_s1 <= 8'h00;
		end else begin
			data_s0 <= i_data_in;
			data_s1 <= data_s0;
		end
	end

	always @(posedge i_clk) begin
		if (i_reset) begin
			state <= ST_IDLE;
			op <= `FSP_OP_READ;
			cnt <= 8'h00;
			prot_map <= 32'h00000000;
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_rdata <= 8'h00;
			o_refused <= 1'b0;
			o_addr <= 21'h000000;
			o_data_out <= 8'h00;
			o_data_oe <= 1'b0;
			o_chip_select_n <= 1'b1;
			o_write_strobe_n <= 1'b1;
			o_output_gate_n <= 1'b1;
			o_id_hv <= 1'b0;
			o_gate_hv <= 1'b0;
			o_clear_hv <= 1'b0;
		end else begin
			o_done <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (i_req) begin
					op <= i_op;
					o_refused <= 1'b0;
					// [RULE_13] temporary unprotect level
					if (i_op == `FSP_OP_TEMP_ON || i_op == `FSP_OP_TEMP_OFF) begin
						// [RULE_14] dropping restores protection
						o_clear_hv <= (i_op == `FSP_OP_TEMP_ON);
						o_done <= 1'b1;
					// [RULE_15] no writes under lockout
					end else if (req_wr && lock_s1) begin
						o_refused <= 1'b1;
						o_done <= 1'b1;
					// [RULE_10] unprotect needs all protected
					end else if (req_unprot && !map_full) begin
						o_refused <= 1'b1;
						o_done <= 1'b1;
					end else begin
						// Unprotect clears every flag in the device
						if (req_unprot) begin
							prot_map <= 32'h00000000;
						end else if (req_prot) begin
							// Assumed to succeed; software verifies by identify read
							prot_map[req_sect] <= 1'b1;
						end
						o_busy <= 1'b1;
						// [RULE_02] sector in top five bits
						o_addr <= i_addr;
						o_data_out <= i_wdata;
						// [RULE_03] id line elevated for identify
						o_id_hv <= (i_op == `FSP_OP_ID_HV) || (i_op == `FSP_OP_ALT_HV);
						// [RULE_11] alternate method elevates gate
						o_gate_hv <= (i_op == `FSP_OP_ALT_HV);
						cnt <= STEP;
						state <= ST_SETUP;
					end
				end
			end
			ST_SETUP: begin
				// Address and levels settle before strobes move
				if (cnt > 8'h01) begin
					cnt <= cnt - 8'h01;
				end else begin
					o_chip_select_n <= 1'b0;
					// [RULE_17] write: gate high, strobe low
					if (is_wr) begin
						o_output_gate_n <= 1'b1;
						o_write_strobe_n <= 1'b0;
						o_data_oe <= 1'b1;
					end else begin
						// [RULE_01] bus read only with gate low
						o_output_gate_n <= 1'b0;
						o_write_strobe_n <= 1'b1;
					end
					// [RULE_16] strobe far wider than glitches
					cnt <= STEP;
					state <= ST_PULSE;
				end
			end
			ST_PULSE: begin
				if (cnt > 8'h01) begin
					cnt <= cnt - 8'h01;
				end else if (is_wr) begin
					o_chip_select_n <= 1'b1;
					o_write_strobe_n <= 1'b1;
					o_output_gate_n <= 1'b1;
					cnt <= STEP;
					state <= ST_HOLD;
				end else begin
					// Gate stays low while the byte crosses the synchroniser
					cnt <= SYNC_WAIT;
					state <= ST_SAMPLE;
				end
			end
			ST_SAMPLE: begin
				if (cnt > 8'h01) begin
					cnt <= cnt - 8'h01;
				end else begin
					// [RULE_04] capture identify or array byte
					o_rdata <= data_s1;
					// [RULE_05] remember reported protection
					if (id_prot_rd) begin
						prot_map[cur_sect] <= data_s1[`FSP_PROT_BIT];
					end
					o_chip_select_n <= 1'b1;
					o_write_strobe_n <= 1'b1;
					o_output_gate_n <= 1'b1;
					cnt <= STEP;
					state <= ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (cnt > 8'h01) begin
					cnt <= cnt - 8'h01;
				end else begin
					o_data_oe <= 1'b0;
					o_id_hv <= 1'b0;
					o_gate_hv <= 1'b0;
					o_busy <= 1'b0;
					o_done <= 1'b1;
					state <= ST_IDLE;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end
endmodule

//--- tb/fsp_flash_model.sv
// Behavioural flash device for the host bench
`timescale 1ns/100ps
module fsp_flash_model #(
	parameter logic [7:0] MAKER = 8'h5a, DEVICE = 8'ha6 // Arbitrary id values
) (
	input  wire logic [20:0] i_a,                              // Address pins
	input  wire logic [7:0]  i_d,                              // Data bus
	input  wire logic        i_cs_n, i_we_n, i_oe_n,           // Control pins
	input  wire logic        i_id, i_gate, i_clr,              // Elevated levels
	output logic      [7:0]  o_d                               // Data to host
);
	logic [31:0] prot = 32'h0;
	logic [7:0] mem [32], rd;
	logic cmd_id = 1'b0;
	wire [4:0] s = i_a[20:16];
	always @* rd = (i_id || cmd_id) ? (i_a[1] ? {7'h0, prot[s]} : i_a[0] ? DEVICE : MAKER) : mem[s];
	assign o_d = i_oe_n ? ~rd : rd;
	// only a falling strobe starts a write
	always @(negedge i_we_n) begin
		#5;
		if (!i_we_n && !i_cs_n && (i_oe_n || i_gate)) begin
			if (i_a[7:0] == 8'h55 && (i_d == 8'h90 || i_d == 8'hf0)) cmd_id <= (i_d == 8'h90);
			else if ((i_clr || i_gate) && i_a[1:0] == 2'h2) prot <= i_a[6] ? 32'h0 : prot | 32'h1 << s;
			else if (!prot[s] || i_clr) mem[s] <= i_d;
		end
	end
endmodule

//--- tb/fsp_host_chk.sv
// Pin protocol checker for the flash host controller
`timescale 1ns/100ps
module fsp_host_chk (
	input wire i_clk, i_reset, i_req, i_lockout, o_busy, o_done, o_refused, o_data_oe,
	input wire o_chip_select_n, o_write_strobe_n, o_output_gate_n, o_id_hv, o_gate_hv, o_clear_hv,
	input wire [2:0] i_op
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	wire go = i_req && !o_busy;
	oe_gate_a: assert property (o_data_oe |-> o_output_gate_n) else $error("bus clash");
	wr_gate_a: assert property (!o_write_strobe_n |-> o_output_gate_n && !o_chip_select_n)
		else $error("bad write");
	id_read_a: assert property (o_id_hv && !o_gate_hv && !o_chip_select_n |-> o_write_strobe_n)
		else $error("bad id read");
	alt_pair_a: assert property (o_gate_hv |-> o_id_hv) else $error("gate alone");
	lock_ref_a: assert property (go && i_op == 3'h1 && i_lockout && $past(i_lockout)
		&& $past(i_lockout, 2) && !$past(i_reset) && !$past(i_reset, 2) |=> o_refused && o_done)
		else $error("lockout write");
	rd_walk_a: assert property (go && i_op == 3'h0 |=> o_busy [*5] ##1 o_done) else $error("rd");
	temp_on_a: assert property (go && i_op == 3'h3 |-> ##[1:2] o_clear_hv) else $error("on");
	temp_off_a: assert property (go && i_op == 3'h4 |-> ##[1:2] !o_clear_hv) else $error("off");
	cover property (o_refused);
	cover property (o_gate_hv && !o_write_strobe_n);
	cover property (o_clear_hv && !o_write_strobe_n);
endmodule
bind fsp_host fsp_host_chk i_chk (.*);

//--- tb/fsp_host_tb_top.sv
// Self-checking bench for the flash host controller
`timescale 1ns/100ps
module fsp_host_tb_top;
	localparam logic [7:0] MK = 8'h3c, DV = 8'hc3; // Arbitrary id values
	logic i_clk = 0, i_reset = 1, i_req = 0, i_lockout = 0;
	logic [2:0] i_op = 0;
	logic [20:0] i_addr = 0, o_addr;
	logic [7:0] i_wdata = 0, o_rdata, o_data_out, q, d;
	logic [4:0] s;
	logic o_busy, o_done, o_refused, o_data_oe, o_chip_select_n, o_write_strobe_n;
	logic o_output_gate_n, o_id_hv, o_gate_hv, o_clear_hv;
	wire [7:0] i_data_in = o_data_oe ? o_data_out : q;
	int errors = 0, tests_run = 0;
	fsp_host i_dut (.*);
	fsp_flash_model #(.MAKER(MK), .DEVICE(DV)) i_mem (.i_a(o_addr), .i_d(i_data_in),
		.i_cs_n(o_chip_select_n), .i_we_n(o_write_strobe_n), .i_oe_n(o_output_gate_n),
		.i_id(o_id_hv), .i_gate(o_gate_hv), .i_clr(o_clear_hv), .o_d(q));
	initial forever #50 i_clk = ~i_clk;
	function automatic logic [20:0] sa(logic [4:0] n, logic [7:0] lo);
		return {n, 8'h0, lo};
	endfunction
	task automatic finish_test;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(logic [7:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask
	task automatic op(logic [2:0] c, logic [20:0] a, logic [7:0] w);
		int n;
		{i_op, i_addr, i_wdata, i_req} <= {c, a, w, 1'b1};
		@(posedge i_clk);
		i_req <= 0;
		// Bounded wait so a hung handshake still reaches the verdict
		for (n = 0; n < 9 && o_done !== 1'b1; n++) @(posedge i_clk);
		if (n == 9) begin
			errors++;
			finish_test;
		end
	endtask
	task automatic rd(logic [2:0] c, logic [20:0] a, logic [7:0] e);
		op(c, a, 0);
		chk(o_rdata, e);
	endtask
	initial begin
		void'($urandom(32'h8de5));
		repeat (3) @(posedge i_clk);
		i_reset <= 0;
		s = $urandom;
		d = $urandom;
		rd(2, sa(s, 0), MK);
		rd(2, sa(s, 1), DV);
		rd(2, sa(s, 2), 0);
		op(1, sa(s, d), d);
		rd(0, sa(s, d), d);
		op(1, 21'h55, 8'h90);
		rd(0, sa(s, 0), MK);
		rd(0, sa(s, 1), DV);
		op(1, 21'h55, 8'hf0);
		rd(0, sa(s, d), d);
		op(5, sa(s, 2), 0);
		rd(2, sa(s, 2), 1);
		op(1, sa(s, 0), ~d);
		rd(0, sa(s, 0), d);
		op(3, 0, 0);
		op(1, sa(s, 0), ~d);
		op(4, 0, 0);
		rd(0, sa(s, 0), ~d);
		op(1, sa(s, 0), d);
		rd(0, sa(s, 0), ~d);
		i_lockout <= 1;
		repeat (3) @(posedge i_clk);
		op(1, 0, 0);
		chk(o_refused, 1);
		i_lockout <= 0;
		op(3, 0, 0);
		op(1, sa(s, 8'h42), 0);
		chk(o_refused, 1);
		rd(2, sa(s, 2), 1);
		for (int i = 0; i < 32; i++) op(1, sa(i, 2), 0);
		op(1, sa(s, 8'h42), 0);
		chk(o_refused, 0);
		op(4, 0, 0);
		op(1, sa(s, 0), d);
		rd(0, sa(s, 0), d);
		finish_test;
	end
endmodule
